//--- include/usm_params.svh
// constants for the serial unit in master spi operation
`ifndef USM_PARAMS_SVH
`define USM_PARAMS_SVH
`define USM_FRAME_BITS     4'd8
`define USM_DIV_RESET      12'h0000
`define USM_MODE_SPI       2'h3
`define USM_CLK_NS         25
`define USM_FIFO_DEPTH     4
`endif

//--- include/usm_pkg.sv
// types shared by the serial unit in master spi operation
`default_nettype none
package usm_pkg;
   typedef enum logic [1:0] {
      USM_IDLE,
      USM_LEAD,
      USM_TRAIL
   } usm_state_t;
   typedef struct packed {
      logic       clockPolarity;
      logic       clockPhase;
      logic       lsbFirst;
   } usm_format_t;
endpackage
`default_nettype wire

//--- src/usm_fifo.sv
// small valid/ready fifo for received bytes
`default_nettype none
module usm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;
   assign inReady  = (count_reg != DEPTH[AW:0]);
   assign outValid = (count_reg != '0);
   assign outData  = mem[rdPtr_reg];
   always_ff @(posedge clock) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else if (flush) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doWrite) wrPtr_reg <= wrPtr_reg + 1'b1;
         if (doRead) rdPtr_reg <= rdPtr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule
`default_nettype wire

//--- src/usm_spi_master.sv
// serial unit running as a full-duplex spi master
// How it works
// - spi master behaviour only when both mode select bits are one
// - one transfer controller drives shifters and buffers; the baud generator runs free of it
// - same ports and flags as the serial mode, only bit meanings differ
// - transfer clock is system clock over two times (divisor plus one)
// - divisor zero gives half the system clock
// - polarity and phase pick one of four sample/setup edge modes
// - data driven and sampled on opposite transfer clock edges
// - eight data bits per frame, msb or lsb first
// - one bit order setting serves receive and transmit paths
// - after a frame start next queued byte or rest data line high
// - double buffered transmit, complete flag only after both bytes leave
// - receiver needs transmitter; transmitter may run alone
// - baud divisor resets to zero
// - writing the data buffer starts a transfer once shifter is free
// - frame error, overrun and parity flags read as zero
// - on receive overflow the newest byte is dropped
`default_nettype none
`include "usm_params.svh"
module usm_spi_master
   import usm_pkg::*;
#(
   parameter int DIV_WIDTH  = 12,
   parameter int RX_DEPTH   = `USM_FIFO_DEPTH
) (
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic [1:0]           operatingModeSelect,
   input  wire usm_format_t          format,
   input  wire logic                 transmitterEnable,
   input  wire logic                 receiverEnable,
   input  wire logic                 baudDivisorWrite,
   input  wire logic [DIV_WIDTH-1:0] baudDivisorIn,
   input  wire logic                 dataWrite,
   input  wire logic [7:0]           dataIn,
   input  wire logic                 dataRead,
   input  wire logic                 txCompleteClear,
   input  wire logic                 dataInput,
   output logic                      transferClock,
   output logic                      dataOutput,
   output logic                      dataOutputEnable,
   output logic [7:0]                dataOut,
   output logic                      receiveCompleteFlag,
   output logic                      transmitCompleteFlag,
   output logic                      dataRegisterEmpty,
   output logic                      frameErrorFlag,
   output logic                      dataOverrunFlag,
   output logic                      parityErrorFlag,
   output logic [DIV_WIDTH-1:0]      baudDivisor
);
   // ---------------------------------------------------------------
   // mode and enables
   // ---------------------------------------------------------------
   wire spiActive = (operatingModeSelect == `USM_MODE_SPI) && transmitterEnable;
   wire rxActive  = spiActive && receiverEnable;

   // ---------------------------------------------------------------
   // baud generator
   // ---------------------------------------------------------------
   logic [DIV_WIDTH-1:0] baudDivisor_reg;
   logic [DIV_WIDTH-1:0] baudCount_reg;
   wire                  halfTick = (baudCount_reg == '0);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         baudDivisor_reg <= `USM_DIV_RESET;
      end else if (baudDivisorWrite) begin
         baudDivisor_reg <= baudDivisorIn;
      end
   end
   // one half period lasts divisor plus one system clocks
   // free-running while idle, so the idle stretch before a frame may be short
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         baudCount_reg <= '0;
      end else if (!spiActive || halfTick) begin
         baudCount_reg <= baudDivisor_reg;
      end else begin
         baudCount_reg <= baudCount_reg - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // transmit buffer
   // ---------------------------------------------------------------
   logic [7:0] txBuffer_reg;
   logic       txFull_reg;
   usm_state_t state_reg;
   usm_state_t state_next;
   logic [3:0] bitCount_reg;
   logic [7:0] txShift_reg;
   logic [7:0] rxShift_reg;
   wire        frameStart = spiActive && (state_reg == USM_IDLE) && txFull_reg;
   wire        lastTrail  = (state_reg == USM_TRAIL) && halfTick
                            && (bitCount_reg == `USM_FRAME_BITS - 4'd1);
   // a frame may reload directly from the buffer on its last edge
   wire        reload     = lastTrail && txFull_reg;
   wire        takeBuffer = frameStart || reload;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txFull_reg   <= 1'b0;
         txBuffer_reg <= 8'h00;
      end else if (!spiActive) begin
         txFull_reg <= 1'b0;
      end else if (dataWrite && !txFull_reg) begin
         txFull_reg   <= 1'b1;
         txBuffer_reg <= dataIn;
      end else if (takeBuffer) begin
         txFull_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // transfer controller
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         USM_IDLE: begin
            if (frameStart) state_next = USM_LEAD;
         end
         USM_LEAD: begin
            if (halfTick) state_next = USM_TRAIL;
         end
         USM_TRAIL: begin
            if (halfTick) begin
               if (bitCount_reg != `USM_FRAME_BITS - 4'd1 || txFull_reg) begin
                  state_next = USM_LEAD;
               end else begin
                  state_next = USM_IDLE;
               end
            end
         end
         default: state_next = USM_IDLE;
      endcase
      if (!spiActive) state_next = USM_IDLE;
   end

   // bit order applies to both shifters
   wire [7:0] loadByte  = txFull_reg ? txBuffer_reg : 8'h00;
   wire [7:0] txShifted = format.lsbFirst ? {1'b1, txShift_reg[7:1]}
                                          : {txShift_reg[6:0], 1'b1};
   wire [7:0] rxShifted = format.lsbFirst ? {dataInput, rxShift_reg[7:1]}
                                          : {rxShift_reg[6:0], dataInput};
   // phase 0 samples on leading edge, phase 1 on trailing edge
   wire       leadEdge   = (state_reg == USM_LEAD) && halfTick;
   wire       trailEdge  = (state_reg == USM_TRAIL) && halfTick;
   wire       sampleEdge = format.clockPhase ? trailEdge : leadEdge;
   wire       setupEdge  = format.clockPhase ? leadEdge : trailEdge;
   logic      pendingSetup_reg;
   // pin follows the shifter's next value, so it moves with the setup edge
   wire [7:0] txShiftNext = takeBuffer ? loadByte
                          : (setupEdge && !pendingSetup_reg) ? txShifted
                          : txShift_reg;
   wire       txBit       = format.lsbFirst ? txShiftNext[0] : txShiftNext[7];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= USM_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bitCount_reg <= 4'd0;
      end else if (takeBuffer) begin
         bitCount_reg <= 4'd0;
      end else if (trailEdge) begin
         bitCount_reg <= bitCount_reg + 4'd1;
      end
   end
   // phase 1 drives the first bit on the first leading edge, so hold it back
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txShift_reg      <= 8'hFF;
         pendingSetup_reg <= 1'b0;
      end else if (takeBuffer) begin
         txShift_reg      <= loadByte;
         pendingSetup_reg <= format.clockPhase;
      end else if (setupEdge && pendingSetup_reg) begin
         pendingSetup_reg <= 1'b0;
      end else if (setupEdge) begin
         txShift_reg <= txShifted;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxShift_reg <= 8'h00;
      end else if (sampleEdge) begin
         rxShift_reg <= rxShifted;
      end
   end

   // ---------------------------------------------------------------
   // receive path and flags
   // ---------------------------------------------------------------
   logic       frameDone_reg;
   logic       rxReady;
   logic       rxValid;
   logic [7:0] rxHead;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         frameDone_reg <= 1'b0;
      end else begin
         frameDone_reg <= lastTrail && spiActive;
      end
   end
   // a full fifo refuses the new byte, so older data survive
   usm_fifo #(
      .WIDTH (8),
      .DEPTH (RX_DEPTH)
   ) rxFifo (
      .clock    (clock),
      .nrst     (nrst),
      .flush    (!rxActive),
      .inData   (rxShift_reg),
      .inValid  (frameDone_reg && rxActive),
      .inReady  (rxReady),
      .outData  (rxHead),
      .outValid (rxValid),
      .outReady (dataRead)
   );

   logic txComplete_reg;
   wire  allSent = lastTrail && !txFull_reg && spiActive;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txComplete_reg <= 1'b0;
      end else if (allSent) begin
         txComplete_reg <= 1'b1; // set wins over clear
      end else if (txCompleteClear) begin
         txComplete_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   wire clockNext = (state_next == USM_TRAIL) ? ~format.clockPolarity
                                              : format.clockPolarity;
   // hold the pin across a sample edge so the slave never latches a moving bit
   wire txBitNext = sampleEdge ? dataOutput
                  : (state_next == USM_IDLE) ? 1'b1 : txBit;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transferClock    <= 1'b0;
         dataOutput       <= 1'b1;
         dataOutputEnable <= 1'b0;
      end else begin
         transferClock    <= clockNext;
         dataOutput       <= txBitNext;
         dataOutputEnable <= spiActive;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dataOut             <= 8'h00;
         receiveCompleteFlag <= 1'b0;
      end else begin
         dataOut             <= rxHead;
         receiveCompleteFlag <= rxValid;
      end
   end
   // status flags lag the internal state by one cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transmitCompleteFlag <= 1'b0;
         dataRegisterEmpty    <= 1'b1;
      end else begin
         transmitCompleteFlag <= txComplete_reg;
         dataRegisterEmpty    <= !txFull_reg;
      end
   end
   // no framing or parity in this mode, so these never set
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         frameErrorFlag  <= 1'b0;
         dataOverrunFlag <= 1'b0;
         parityErrorFlag <= 1'b0;
      end else begin
         frameErrorFlag  <= 1'b0;
         dataOverrunFlag <= 1'b0;
         parityErrorFlag <= 1'b0;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         baudDivisor <= `USM_DIV_RESET;
      end else begin
         baudDivisor <= baudDivisor_reg;
      end
   end
   wire unusedReady = rxReady;
endmodule
`default_nettype wire

//--- bench/usm_checker.sv
// assertions for the spi master serial unit
`default_nettype none
module usm_checker
   import usm_pkg::*;
#(
   parameter int DIV_WIDTH = 12
) (
   input wire logic                 clock,
   input wire logic                 nrst,
   input wire logic [1:0]           operatingModeSelect,
   input wire usm_format_t          format,
   input wire logic                 transmitterEnable,
   input wire logic                 dataWrite,
   input wire logic                 transferClock,
   input wire logic                 dataOutput,
   input wire logic                 dataOutputEnable,
   input wire logic                 receiveCompleteFlag,
   input wire logic                 transmitCompleteFlag,
   input wire logic                 dataRegisterEmpty,
   input wire logic                 frameErrorFlag,
   input wire logic                 dataOverrunFlag,
   input wire logic                 parityErrorFlag,
   input wire logic [DIV_WIDTH-1:0] baudDivisor
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] runLen;
   logic        active;
   assign active = operatingModeSelect == 2'h3 && transmitterEnable;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // starts saturated so a clock that settles right after reset never trips
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) runLen <= 16'hffff;
      else if ($changed(transferClock)) runLen <= 16'h0000;
      else if (runLen != 16'hffff) runLen <= runLen + 16'h0001;
   end
   a_err_flags_zero: assert property (!(frameErrorFlag | dataOverrunFlag | parityErrorFlag))
      else $error("receive error flag set");
   a_mode_gate_pin: assert property (operatingModeSelect != 2'h3 &&
      $past(operatingModeSelect) != 2'h3 |-> !dataOutputEnable) else $error("pin driven");
   a_div_reset_zero: assert property ($rose(nrst) |-> baudDivisor == '0)
      else $error("divisor not zero after reset");
   a_clock_half_len: assert property ($changed(transferClock) |-> runLen >= 16'(baudDivisor))
      else $error("clock half too short");
   a_write_starts_clk: assert property (dataWrite && dataRegisterEmpty && active &&
      baudDivisor < 4 |-> ##[1:12] $changed(transferClock)) else $error("write did not start");
   a_txc_after_drain: assert property ($rose(transmitCompleteFlag) |-> dataRegisterEmpty)
      else $error("complete with byte queued");
   a_idle_clock_level: assert property ($rose(transmitCompleteFlag) |->
      transferClock == format.clockPolarity) else $error("idle clock level wrong");
   a_idle_data_high: assert property ($rose(transmitCompleteFlag) |-> dataOutput)
      else $error("idle data not high");
   a_flush_on_off: assert property ($fell(transmitterEnable) |-> ##[1:3] !receiveCompleteFlag)
      else $error("receive buffer not flushed");
   c_done: cover property ($rose(transmitCompleteFlag));
   c_fast_clock: cover property ($changed(transferClock) && baudDivisor == '0);
   c_rx_pending_write: cover property (receiveCompleteFlag && dataWrite);
endmodule
bind usm_spi_master usm_checker #(.DIV_WIDTH(DIV_WIDTH)) usm_checker_i (
   .clock, .nrst, .operatingModeSelect, .format, .transmitterEnable, .dataWrite,
   .transferClock, .dataOutput, .dataOutputEnable, .receiveCompleteFlag,
   .transmitCompleteFlag, .dataRegisterEmpty, .frameErrorFlag, .dataOverrunFlag,
   .parityErrorFlag, .baudDivisor
);
`default_nettype wire

//--- bench/usm_spi_slave.sv
// behavioural spi slave on the far side of the serial unit
`default_nettype none
module usm_spi_slave
   import usm_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resync,
   input  wire usm_format_t format,
   input  wire logic        transferClock,
   input  wire logic        dataOutput,
   input  wire logic [7:0]  slaveByte,
   output logic             dataInput,
   output logic [7:0]       gotByte,
   output int               frames
);
   timeunit 1ns;
   timeprecision 100ps;
   int         edges = 0;
   int         idx;
   logic [7:0] rxShift = 8'h00;
   logic [7:0] txByte;
   logic       junk = 1'b0;
   initial frames = 0;
   initial gotByte = 8'h00;
   assign txByte = slaveByte + 8'(frames);
   assign idx = format.clockPhase ? (edges + 1) / 2 - 1 : edges / 2;
   // with phase 1 the line wanders outside a frame, so a stray sample never finds a stale bit
   always @(posedge clock) junk <= ~junk;
   assign dataInput = (idx < 0 || idx > 7) ? junk :
                      format.lsbFirst ? txByte[idx] : txByte[7 - idx];
   always @(transferClock) begin
      if (resync) begin
         edges = 0;
      end else begin
         edges++;
         if (transferClock == (format.clockPolarity == format.clockPhase)) begin
            rxShift = format.lsbFirst ? {dataOutput, rxShift[7:1]} : {rxShift[6:0], dataOutput};
         end
         if (edges == 16) begin
            gotByte = rxShift;
            frames++;
            edges = 0;
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the spi master serial unit
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench
   import usm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          seed = 59319;
   int          cyc = 0;
   int          nf = 0;
   int          frames;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  mode = 2'h3;
   usm_format_t fmt = '0;
   logic        txEn = 1'b0;
   logic        rxEn = 1'b0;
   logic        divWr = 1'b0;
   logic [11:0] divIn = 12'h000;
   logic        wr = 1'b0;
   logic [7:0]  din = 8'h00;
   logic        rd = 1'b0;
   logic        txcClr = 1'b0;
   // held until the first setup so the clock's reset edge is not counted
   logic        resync = 1'b1;
   logic [7:0]  slv = 8'h00;
   logic [7:0]  got, dout;
   logic [11:0] div;
   logic        miso, sck, mosi, oe, rcf, txc, dre, fe, dov, pe;
   usm_spi_master usm_spi_master_i (
      .clock, .nrst, .operatingModeSelect(mode), .format(fmt), .transmitterEnable(txEn),
      .receiverEnable(rxEn), .baudDivisorWrite(divWr), .baudDivisorIn(divIn),
      .dataWrite(wr), .dataIn(din), .dataRead(rd), .txCompleteClear(txcClr),
      .dataInput(miso), .transferClock(sck), .dataOutput(mosi), .dataOutputEnable(oe),
      .dataOut(dout), .receiveCompleteFlag(rcf), .transmitCompleteFlag(txc),
      .dataRegisterEmpty(dre), .frameErrorFlag(fe), .dataOverrunFlag(dov),
      .parityErrorFlag(pe), .baudDivisor(div));
   usm_spi_slave usm_spi_slave_i (
      .clock, .resync, .format(fmt), .transferClock(sck), .dataOutput(mosi),
      .slaveByte(slv), .dataInput(miso), .gotByte(got), .frames);
   always #12.5 clock = ~clock;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   function automatic logic [7:0] slvAt(int n);
      return slv + 8'(n);
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(negedge clock);
   endtask
   task automatic setup(usm_format_t f, logic [11:0] d);
      resync = 1'b1;
      fmt = f;
      divIn = d;
      divWr = 1'b1;
      tick();
      divWr = 1'b0;
      tick();
      resync = 1'b0;
      `CHK("divisor readback", d, div)
   endtask
   task automatic send(logic [7:0] b);
      int k;
      k = 0;
      while (dre !== 1'b1 && k < 999) begin
         tick();
         k++;
      end
      wr = 1'b1;
      din = b;
      tick();
      wr = 1'b0;
      // flags lag a cycle; let the buffer state show before the next write
      tick();
   endtask
   task automatic settle;
      int k;
      k = 0;
      while (txc !== 1'b1 && k < 999) begin
         tick();
         k++;
      end
      tick();
   endtask
   task automatic pop(logic [7:0] e);
      `CHK("rx flag", 1'b1, rcf)
      `CHK("rx byte", e, dout)
      rd = 1'b1;
      tick();
      rd = 1'b0;
      tick(2);
   endtask
   task automatic xfer(logic [7:0] b);
      txcClr = 1'b1;
      tick();
      txcClr = 1'b0;
      send(b);
      settle();
      nf++;
      `CHK("frames", nf, frames)
      `CHK("sent byte", b, got)
      `CHK("idle data", 1'b1, mosi)
      `CHK("idle clock", fmt.clockPolarity, sck)
      `CHK("error flags", 3'h0, {fe, dov, pe})
   endtask
   initial begin
      tick(3);
      nrst = 1'b1;
      tick();
      `CHK("divisor", 12'h000, div)
      `CHK("empty", 1'b1, dre)
      txEn = 1'b1;
      rxEn = 1'b1;
      tick();
      `CHK("pin drive", 1'b1, oe)
      for (int m = 0; m < 8; m++) begin
         setup(usm_format_t'(3'(m)), 12'($unsigned($random(seed)) % 4));
         slv = 8'($random(seed));
         xfer(8'($random(seed)));
         pop(slvAt(nf - 1));
      end
      $display("test modes done");
      setup(fmt, 12'h000);
      txcClr = 1'b1;
      tick();
      txcClr = 1'b0;
      send(8'h80);
      send(8'h01);
      `CHK("early done", 1'b0, txc)
      settle();
      nf += 2;
      `CHK("pair frames", nf, frames)
      `CHK("second byte", 8'h01, got)
      pop(slvAt(nf - 2));
      pop(slvAt(nf - 1));
      $display("test pair done");
      for (int i = 0; i < 5; i++) xfer(8'($random(seed)));
      for (int i = 5; i > 1; i--) pop(slvAt(nf - i));
      `CHK("newest dropped", 1'b0, rcf)
      $display("test overflow done");
      for (int m = 0; m < 3; m++) begin
         mode = 2'(m);
         tick(2);
         `CHK("pin released", 1'b0, oe)
         send(8'h5a);
         tick(20);
         `CHK("ignored write", nf, frames)
      end
      mode = 2'h3;
      tick(2);
      $display("test inactive done");
      rxEn = 1'b0;
      tick();
      xfer(8'h3c);
      `CHK("tx alone rx", 1'b0, rcf)
      rxEn = 1'b1;
      tick();
      $display("test tx alone done");
      xfer(8'hc3);
      txEn = 1'b0;
      tick(3);
      `CHK("flushed", 1'b0, rcf)
      $display("test disable done");
      stop_test();
   end
endmodule
`default_nettype wire
